// ---- core/pud_dead_time.sv ----
`timescale 1ns/1ns
`default_nettype none
module pud_dead_time (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic start_in,
    input wire logic [pud_pkg::PS_W-1:0] prescale_in,
    input wire logic [pud_pkg::CNT_W-1:0] count_in,
    output logic busy_out,
    output logic done_out
);
    import pud_pkg::*;

    logic [CNT_W-1:0] remain_q, remain_d;
    logic [2:0] pre_q, pre_d, lim_q, lim_d;
    logic done_q, done_d;

    // Last prescaler value before a dead-time tick
    function automatic logic [2:0] pud_ps_limit(input logic [PS_W-1:0] ps);
        case (ps)
            2'h0: return 3'h0;
            2'h1: return 3'h1;
            2'h2: return 3'h3;
            default: return 3'h7;
        endcase
    endfunction

    // Prescale latched at start so a mid-run write cannot stretch the gap
    always_comb begin
        remain_d = remain_q;
        pre_d = pre_q;
        lim_d = lim_q;
        done_d = 1'b0;
        if (start_in) begin
            lim_d = pud_ps_limit(prescale_in);
            remain_d = count_in;
            pre_d = 3'h0;
        end else if (remain_q != '0) begin
            if (pre_q == lim_q) begin
                pre_d = 3'h0;
                remain_d = remain_q - 6'h01;
                done_d = (remain_q == 6'h01);
            end else begin
                pre_d = pre_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            remain_q <= '0;
            pre_q <= 3'h0;
            lim_q <= 3'h0;
            done_q <= 1'b0;
        end else begin
            remain_q <= remain_d;
            pre_q <= pre_d;
            lim_q <= lim_d;
            done_q <= done_d;
        end
    end

    assign busy_out = (remain_q != '0);
    assign done_out = done_q;

    // Helper: busy length against count times period
    logic [9:0] hlp_cnt_q, hlp_exp_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hlp_cnt_q <= 10'h000;
            hlp_exp_q <= 10'h000;
        end else if (start_in) begin
            hlp_cnt_q <= 10'h000;
            hlp_exp_q <= 10'(count_in) << prescale_in;
        end else if (busy_out) begin
            hlp_cnt_q <= hlp_cnt_q + 10'h001;
        end
    end

    dt_length_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        done_out |-> hlp_cnt_q == hlp_exp_q)
        else $error("dead time length wrong");
    dt_zero_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (start_in && count_in == 6'h00) |=> !busy_out)
        else $error("zero dead time went busy");
endmodule
`default_nettype wire

// ---- core/pud_top.sv ----
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Special events are divided by postscale code plus one.
// - Immediate-update bit set applies duty writes at once, else at time base.
// - Without immediate-update support the bit reads zero and updates stay synced.
// - Unit B prescale codes give 1, 2, 4 or 8 cycle periods.
// - Unit B dead time is its 6-bit count times its period.
// - Unit A prescale codes give 1, 2, 4 or 8 cycle periods.
// - Unit A dead time is its 6-bit count times its period.
// - Per edge select bit picks unit B when set, unit A when clear.
// - Event when time base count and direction match compare value.
module pud_top #(
    parameter bit IUE_PRESENT = 1'b1
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire pud_pkg::pud_bus_req_t bus_in,
    output logic [15:0] rdata_out,
    input wire logic [pud_pkg::TB_W-1:0] tb_count_in,
    input wire logic tb_down_in,
    input wire logic tb_sync_in,
    input wire logic [15:0] duty_buf_in,
    input wire logic duty_wr_in,
    input wire logic [pud_pkg::TB_W-1:0] period_buf_in,
    input wire logic [7:0] override_in,
    input wire logic override_wr_in,
    input wire pud_pkg::pud_edge_t edge_in,
    output logic [15:0] duty_active_out,
    output logic [pud_pkg::TB_W-1:0] period_active_out,
    output logic [7:0] override_out,
    output logic event_trig_out,
    output logic dead_busy_out,
    output logic dead_done_out,
    output logic irq_out
);
    import pud_pkg::*;

    // Write hit for one register offset
    function automatic logic pud_wr_hit(input pud_bus_req_t b, input logic [2:0] ofs);
        return b.wr && (b.addr == ofs);
    endfunction

    logic [15:0] ctrl_q, ctrl_d, dtcfg_q, dtcfg_d, cmp_q, cmp_d;
    logic [15:0] rdata_q, rdata_d, ctrl_wmask;
    logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, stat_set, stat_clr;
    logic buffer_update_disable, override_sync_en, iue_eff;
    logic [POST_W-1:0] post_sel;
    logic match, ev;
    logic match_q, match_d, trig_q, trig_d;
    logic [POST_W-1:0] post_q, post_d;
    logic [15:0] duty_q, duty_d;
    logic [TB_W-1:0] period_q, period_d;
    logic [7:0] ovr_q, ovr_d, hold_q, hold_d;
    logic pend_q, pend_d, xfer, ovr_ev;
    logic start_a, start_b, busy_a, busy_b, done_a, done_b;

    // Field views of the control register
    assign buffer_update_disable = ctrl_q[CTRL_BUFFER_UPDATE_DISABLE_BIT];
    assign override_sync_en = ctrl_q[CTRL_OVERRIDE_SYNC_EN_BIT];
    assign iue_eff = IUE_PRESENT && ctrl_q[CTRL_IUE_BIT];
    assign post_sel = ctrl_q[CTRL_POST_LSB +: POST_W];

    // Register file next state
    always_comb begin
        ctrl_wmask = IUE_PRESENT ? CTRL_MASK : (CTRL_MASK & ~CTRL_IUE_MASK);
        ctrl_d = ctrl_q;
        dtcfg_d = dtcfg_q;
        cmp_d = cmp_q;
        mask_d = mask_q;
        stat_clr = '0;
        if (pud_wr_hit(bus_in, OFS_CTRL)) begin
            ctrl_d = bus_in.wdata & ctrl_wmask;
        end
        if (pud_wr_hit(bus_in, OFS_DTCFG)) begin
            dtcfg_d = bus_in.wdata;
        end
        if (pud_wr_hit(bus_in, OFS_CMP)) begin
            cmp_d = bus_in.wdata;
        end
        if (pud_wr_hit(bus_in, OFS_MASK)) begin
            mask_d = bus_in.wdata[IRQ_W-1:0];
        end
        if (pud_wr_hit(bus_in, OFS_STAT)) begin
            stat_clr = bus_in.wdata[IRQ_W-1:0];
        end
        // Set beats a same-cycle clear so no event is lost
        stat_d = (stat_q & ~stat_clr) | stat_set;
        rdata_d = 16'h0000;
        if (bus_in.rd) begin
            case (bus_in.addr)
                OFS_CTRL: rdata_d = ctrl_q;
                OFS_DTCFG: rdata_d = dtcfg_q;
                OFS_CMP: rdata_d = cmp_q;
                OFS_STAT: rdata_d = 16'(stat_q);
                OFS_MASK: rdata_d = 16'(mask_q);
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_q <= CTRL_RST;
            dtcfg_q <= DTCFG_RST;
            cmp_q <= CMP_RST;
            stat_q <= STAT_RST;
            mask_q <= MASK_RST;
            rdata_q <= 16'h0000;
        end else begin
            ctrl_q <= ctrl_d;
            dtcfg_q <= dtcfg_d;
            cmp_q <= cmp_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    assign match = (tb_count_in == cmp_q[TB_W-1:0]) && (tb_down_in == cmp_q[CMP_DIR_BIT]);
    // Only the first matching cycle counts, a parked time base fires once
    assign ev = match && !match_q;

    // Postscaler next state
    always_comb begin
        match_d = match;
        post_d = post_q;
        trig_d = 1'b0;
        if (ev) begin
            if (post_q >= post_sel) begin
                post_d = '0;
                trig_d = 1'b1;
            end else begin
                post_d = post_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            match_q <= 1'b0;
            post_q <= '0;
            trig_q <= 1'b0;
        end else begin
            match_q <= match_d;
            post_q <= post_d;
            trig_q <= trig_d;
        end
    end

    // Duty, period and override transfers
    always_comb begin
        duty_d = duty_q;
        period_d = period_q;
        ovr_d = ovr_q;
        hold_d = hold_q;
        pend_d = pend_q;
        xfer = 1'b0;
        ovr_ev = 1'b0;
        if (!buffer_update_disable) begin
            // Period moves at the time base even beside an immediate duty write
            if (tb_sync_in) begin
                duty_d = duty_buf_in;
                period_d = period_buf_in;
                xfer = 1'b1;
            end
            if (duty_wr_in && iue_eff) begin
                duty_d = duty_buf_in;
                xfer = 1'b1;
            end
        end
        if (override_wr_in) begin
            hold_d = override_in;
            pend_d = 1'b1;
        end
        if (override_wr_in && !override_sync_en) begin
            ovr_d = override_in;
            pend_d = 1'b0;
            ovr_ev = 1'b1;
        end else if (override_sync_en && tb_sync_in && (pend_q || override_wr_in)) begin
            ovr_d = override_wr_in ? override_in : hold_q;
            pend_d = 1'b0;
            ovr_ev = 1'b1;
        end else if (!override_sync_en && pend_q) begin
            ovr_d = hold_q;
            pend_d = 1'b0;
            ovr_ev = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            duty_q <= 16'h0000;
            period_q <= '0;
            ovr_q <= 8'h00;
            hold_q <= 8'h00;
            pend_q <= 1'b0;
        end else begin
            duty_q <= duty_d;
            period_q <= period_d;
            ovr_q <= ovr_d;
            hold_q <= hold_d;
            pend_q <= pend_d;
        end
    end

    assign start_a = (edge_in.go_active && !edge_in.sel_active) ||
                     (edge_in.go_inactive && !edge_in.sel_inactive);
    assign start_b = (edge_in.go_active && edge_in.sel_active) ||
                     (edge_in.go_inactive && edge_in.sel_inactive);

    pud_dead_time u_dt_a (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .start_in(start_a),
        .prescale_in(dtcfg_q[DT_A_PS_LSB +: PS_W]),
        .count_in(dtcfg_q[DT_A_CNT_LSB +: CNT_W]),
        .busy_out(busy_a),
        .done_out(done_a)
    );

    pud_dead_time u_dt_b (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .start_in(start_b),
        .prescale_in(dtcfg_q[DT_B_PS_LSB +: PS_W]),
        .count_in(dtcfg_q[DT_B_CNT_LSB +: CNT_W]),
        .busy_out(busy_b),
        .done_out(done_b)
    );

    // Interrupt sources, one bit each
    always_comb begin
        stat_set = '0;
        stat_set[ST_TRIG_BIT] = trig_d;
        stat_set[ST_XFER_BIT] = xfer;
        stat_set[ST_OVR_BIT] = ovr_ev;
        stat_set[ST_DT_BIT] = done_a || done_b;
    end

    // Outputs
    assign rdata_out = rdata_q;
    assign duty_active_out = duty_q;
    assign period_active_out = period_q;
    assign override_out = ovr_q;
    assign event_trig_out = trig_q;
    assign dead_busy_out = busy_a || busy_b;
    assign dead_done_out = done_a || done_b;
    assign irq_out = |(stat_q & mask_q);

    post_pass_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ev && post_q >= post_sel) |=> event_trig_out && post_q == 4'h0)
        else $error("postscaler failed to pass event");
    post_block_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ev && post_q < post_sel) |=> !event_trig_out && post_q == $past(post_q) + 4'h1)
        else $error("postscaler passed early");
    duty_imm_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (duty_wr_in && iue_eff && !buffer_update_disable) |=> duty_active_out == $past(duty_buf_in))
        else $error("immediate duty not applied");
    duty_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!tb_sync_in && !(duty_wr_in && iue_eff)) |=> $stable(duty_active_out))
        else $error("duty changed off sync");
    iue_absent_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (bus_in.rd && bus_in.addr == OFS_CTRL && !IUE_PRESENT) |=> !rdata_out[CTRL_IUE_BIT])
        else $error("absent update bit read as one");
    ovr_next_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (override_wr_in && !override_sync_en) |=> override_out == $past(override_in))
        else $error("override not applied next cycle");
    ovr_wait_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (override_sync_en && !tb_sync_in) |=> $stable(override_out))
        else $error("synced override applied early");
    buffer_update_disable_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        buffer_update_disable |=> $stable(duty_active_out) && $stable(period_active_out))
        else $error("transfer while updates disabled");
    event_once_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (match && !match_q && post_sel == 4'h0) |=> event_trig_out ##1 !event_trig_out)
        else $error("event trigger wrong");
    rsv_zero_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (bus_in.rd && bus_in.addr == OFS_CTRL) |=> (rdata_out & ~CTRL_MASK) == 16'h0000)
        else $error("reserved bits read nonzero");
    sync_xfer_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (tb_sync_in && !buffer_update_disable) |=> period_active_out == $past(period_buf_in))
        else $error("period not moved at time base");
    ovr_sync_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (override_sync_en && tb_sync_in && pend_q && !override_wr_in) |=> override_out == $past(hold_q))
        else $error("held override not applied at time base");
    unit_a_sel_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (((edge_in.go_active && !edge_in.sel_active) ||
          (edge_in.go_inactive && !edge_in.sel_inactive)) &&
         dtcfg_q[DT_A_CNT_LSB +: CNT_W] != 6'h00) |=> busy_a)
        else $error("unit A not started on its edge");
    unit_b_sel_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (((edge_in.go_active && edge_in.sel_active) ||
          (edge_in.go_inactive && edge_in.sel_inactive)) &&
         dtcfg_q[DT_B_CNT_LSB +: CNT_W] != 6'h00) |=> busy_b)
        else $error("unit B not started on its edge");
endmodule
`default_nettype wire

// ---- pkg/pud_pkg.sv ----
package pud_pkg;
    // Register offsets on the plain register port
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_DTCFG = 3'h1;
    localparam logic [2:0] OFS_CMP = 3'h2;
    localparam logic [2:0] OFS_STAT = 3'h3;
    localparam logic [2:0] OFS_MASK = 3'h4;

    // Update control and event postscale fields
    localparam int CTRL_BUFFER_UPDATE_DISABLE_BIT = 0;
    localparam int CTRL_OVERRIDE_SYNC_EN_BIT = 1;
    localparam int CTRL_IUE_BIT = 2;
    localparam int CTRL_POST_LSB = 8;
    localparam int POST_W = 4;
    localparam logic [15:0] CTRL_MASK = 16'h0f07;
    localparam logic [15:0] CTRL_IUE_MASK = 16'h0004;

    // Dead-time unit configuration fields
    localparam int DT_A_CNT_LSB = 0;
    localparam int DT_A_PS_LSB = 6;
    localparam int DT_B_CNT_LSB = 8;
    localparam int DT_B_PS_LSB = 14;
    localparam int CNT_W = 6;
    localparam int PS_W = 2;

    // Event compare fields
    localparam int TB_W = 15;
    localparam int CMP_DIR_BIT = 15;

    // Interrupt status layout
    localparam int IRQ_W = 4;
    localparam int ST_TRIG_BIT = 0;
    localparam int ST_XFER_BIT = 1;
    localparam int ST_OVR_BIT = 2;
    localparam int ST_DT_BIT = 3;

    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] DTCFG_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] STAT_RST = 4'h0;
    localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pud_bus_req_t;

    typedef struct packed {
        logic go_active;
        logic go_inactive;
        logic sel_active;
        logic sel_inactive;
    } pud_edge_t;
endpackage

// ---- verification/pud_gate_drv.sv ----
`timescale 1ns/1ns
`default_nettype none
module pud_gate_drv (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic busy_in,
    input wire logic done_in,
    output var int blank_len_out,
    output var int done_cnt_out
);
    int run_q;

    // Driver held off while blanking; time the off interval to see the dead time
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            run_q <= 0;
            blank_len_out <= 0;
            done_cnt_out <= 0;
        end else begin
            run_q <= busy_in ? run_q + 1 : 0;
            if (!busy_in && run_q != 0) begin
                blank_len_out <= run_q;
            end
            if (done_in) begin
                done_cnt_out <= done_cnt_out + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/pud_top_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module pud_top_tb_top;
    import pud_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    pud_bus_req_t bus = '0;
    logic [TB_W-1:0] tb_cnt = '0;
    logic tb_down = 1'b0;
    logic tb_sync = 1'b0;
    logic [15:0] duty_buf = 16'h0000;
    logic duty_wr = 1'b0;
    logic [TB_W-1:0] per_buf = '0;
    logic [7:0] ovr = 8'h00;
    logic ovr_wr = 1'b0;
    pud_edge_t edg = '0;
    logic [15:0] rdata, rdata_b, duty_act, duty_b, rd_a, rd_b;
    logic [TB_W-1:0] per_act;
    logic [7:0] ovr_out;
    logic trig, busy, done, irq;
    logic [3:0] codes [3] = '{4'h0, 4'h1, 4'hf};
    int n_mismatch = 0;
    int n_tests = 0;
    int n_ev = 0;
    int e0;
    int blank_len, done_cnt;

    always #25 clk_in = ~clk_in;

    // Count postscaled trigger pulses
    always @(posedge clk_in) begin
        if (trig === 1'b1) begin
            n_ev <= n_ev + 1;
        end
    end

    pud_top #(.IUE_PRESENT(1'b1)) i_pud_top (
        .clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus), .rdata_out(rdata),
        .tb_count_in(tb_cnt), .tb_down_in(tb_down), .tb_sync_in(tb_sync),
        .duty_buf_in(duty_buf), .duty_wr_in(duty_wr), .period_buf_in(per_buf),
        .override_in(ovr), .override_wr_in(ovr_wr), .edge_in(edg),
        .duty_active_out(duty_act), .period_active_out(per_act),
        .override_out(ovr_out), .event_trig_out(trig), .dead_busy_out(busy),
        .dead_done_out(done), .irq_out(irq)
    );

    // Variant without the immediate-update bit, sharing all stimulus
    pud_top #(.IUE_PRESENT(1'b0)) i_pud_top_b (
        .clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus), .rdata_out(rdata_b),
        .tb_count_in(tb_cnt), .tb_down_in(tb_down), .tb_sync_in(tb_sync),
        .duty_buf_in(duty_buf), .duty_wr_in(duty_wr), .period_buf_in(per_buf),
        .override_in(ovr), .override_wr_in(ovr_wr), .edge_in(edg),
        .duty_active_out(duty_b), .period_active_out(), .override_out(),
        .event_trig_out(), .dead_busy_out(), .dead_done_out(), .irq_out()
    );

    pud_gate_drv i_pud_gate_drv (
        .clk_in(clk_in), .resetn_in(resetn_in), .busy_in(busy), .done_in(done),
        .blank_len_out(blank_len), .done_cnt_out(done_cnt)
    );

    task automatic summarize;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_in);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_in);
        bus <= '0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge clk_in);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_in);
        bus <= '0;
        #1;
        rd_a = rdata;
        rd_b = rdata_b;
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [15:0] exp);
        rd(a);
        chk(rd_a, exp);
    endtask

    // One-cycle strobes: bit 0 duty write, bit 1 time base sync, bit 2 override write
    task automatic strobe(input logic [2:0] s);
        @(posedge clk_in);
        duty_wr <= s[0];
        tb_sync <= s[1];
        ovr_wr <= s[2];
        @(posedge clk_in);
        duty_wr <= 1'b0;
        tb_sync <= 1'b0;
        ovr_wr <= 1'b0;
        #1;
    endtask

    task automatic events(input int n, input logic dir);
        repeat (n) begin
            @(posedge clk_in);
            tb_cnt <= 15'h0010;
            tb_down <= dir;
            @(posedge clk_in);
            tb_cnt <= 15'h0000;
        end
        tick(3);
    endtask

    // Start one dead interval on the chosen unit and edge, then time it
    task automatic dead(input logic [1:0] ps, input logic [5:0] cnt, input logic b,
                        input logic inact);
        int d0;
        int b0;
        d0 = done_cnt;
        b0 = blank_len;
        wr(OFS_DTCFG, b ? {ps, cnt, 8'h00} : {8'h00, ps, cnt});
        @(posedge clk_in);
        // The unused edge selects the other unit, so a swapped select times out
        edg <= '{~inact, inact, b ^ inact, b ^ ~inact};
        @(posedge clk_in);
        edg <= '0;
        for (int i = 0; i < 700 && done_cnt == d0 && cnt != 6'h00; i++) @(posedge clk_in);
        if (done_cnt == d0 && cnt != 6'h00) begin
            n_mismatch++;
            summarize();
        end
        tick(3);
        chk(16'(done_cnt - d0), {15'h0000, cnt != 6'h00});
        chk(16'(blank_len), (cnt == 6'h00) ? 16'(b0) : 16'(cnt) << ps);
    endtask

    initial begin
        tick(12);
        resetn_in <= 1'b1;
        rdchk(OFS_CTRL, CTRL_RST);
        rdchk(OFS_DTCFG, DTCFG_RST);
        wr(OFS_CTRL, 16'hffff);
        rd(OFS_CTRL);
        chk(rd_a, CTRL_MASK);
        chk(rd_b, CTRL_MASK & ~CTRL_IUE_MASK);
        wr(OFS_DTCFG, 16'hffff);
        rdchk(OFS_DTCFG, 16'hffff);
        rdchk(3'h7, 16'h0000);
        wr(OFS_CTRL, 16'h0000);
        // Postscale codes 0, 1 and 15 must each pass exactly two of (code+1)*2 events
        wr(OFS_CMP, 16'h0010);
        wr(OFS_MASK, 16'h0001);
        for (int k = 0; k < 3; k++) begin
            wr(OFS_CTRL, {4'h0, codes[k], 8'h00});
            e0 = n_ev;
            events((int'(codes[k]) + 1) * 2, 1'b0);
            chk(16'(n_ev - e0), 16'h0002);
        end
        e0 = n_ev;
        events(2, 1'b1);
        chk(16'(n_ev - e0), 16'h0000);
        // Down-counting compare passes an event on a down count
        wr(OFS_CTRL, 16'h0000);
        wr(OFS_CMP, 16'h8010);
        e0 = n_ev;
        events(1, 1'b1);
        chk(16'(n_ev - e0), 16'h0001);
        chk(16'(irq), 16'h0001);
        wr(OFS_MASK, 16'h0000);
        tick(1);
        chk(16'(irq), 16'h0000);
        wr(OFS_MASK, 16'h0001);
        rdchk(OFS_STAT, 16'h0001);
        wr(OFS_STAT, 16'h0001);
        tick(1);
        chk(16'(irq), 16'h0000);
        // Duty takes effect at once only with immediate update
        wr(OFS_CTRL, 16'h0004);
        duty_buf <= 16'h1234;
        per_buf <= 15'h0100;
        strobe(3'b001);
        chk(duty_act, 16'h1234);
        chk(duty_b, 16'h0000);
        wr(OFS_CTRL, 16'h0000);
        duty_buf <= 16'h5678;
        strobe(3'b001);
        chk(duty_act, 16'h1234);
        strobe(3'b010);
        chk(duty_act, 16'h5678);
        chk(16'(per_act), 16'h0100);
        // Update disable blocks both paths, even with a sync in the same cycle
        wr(OFS_CTRL, 16'h0005);
        duty_buf <= 16'h9abc;
        per_buf <= 15'h0200;
        strobe(3'b011);
        chk(duty_act, 16'h5678);
        chk(16'(per_act), 16'h0100);
        wr(OFS_CTRL, 16'h0000);
        strobe(3'b010);
        chk(duty_act, 16'h9abc);
        chk(16'(per_act), 16'h0200);
        // Override: next cycle when unsynced, else held for the time base
        tick(1);
        ovr <= 8'ha5;
        strobe(3'b100);
        chk(16'(ovr_out), 16'h00a5);
        wr(OFS_CTRL, 16'h0002);
        ovr <= 8'h3c;
        strobe(3'b100);
        tick(2);
        #1;
        chk(16'(ovr_out), 16'h00a5);
        strobe(3'b010);
        chk(16'(ovr_out), 16'h003c);
        // Both units, all prescales, both edge kinds, plus count limits
        for (int b = 0; b < 2; b++) begin
            for (int p = 0; p < 4; p++) begin
                dead(2'(p), 6'h03, 1'(b), p[0]);
            end
        end
        dead(2'h0, 6'h3f, 1'b0, 1'b0);
        dead(2'h3, 6'h3f, 1'b1, 1'b1);
        dead(2'h3, 6'h00, 1'b1, 1'b0);
        rdchk(OFS_STAT, 16'h000e);
        summarize();
    end
endmodule
`default_nettype wire
